// ### rtl/gpm_pkg.sv
// constants shared by the general-purpose port pin mux design
// assumes a single 250 MHz clock and an APB register bus of 32-bit data
// Notes on behaviour
// - first port is eight bidirectional digital pins that drive or sense
// - each first-port pin has its own direction bit
// - any reset leaves every first-port pin an input, driver off
// - large package: port functions only while external bus disable is set
// - external bus enabled: first port is address/data low byte, direction ignored
// - parallel pin select 1: first port is parallel data, below external bus
// - first-port inputs are TTL while parallel port active and external bus not, Schmitt otherwise
// - clearing the shared pull-up bit turns off all first-port pull-ups
// - a first-port pin set as output has its pull-up off
// - every reset leaves first-port pull-ups disabled
// - writing port data loads the output latch like a latch write
// - large package: second-port pins 0-4 carry bus bits 8-12, TTL inputs
// - second-port pins carry parallel read, write, byte enable, address 13, 12
// - parallel read and write pins also act as TTL inputs
// - second-port pins output PWM channels; need direction 0; beat port, parallel
// - each PWM output may float during a shutdown event
// - functions that ignore direction take pin direction from the peripheral
// - external bus signals beat every other function on shared pins
// - parallel default pins apply when its pin-select option is 1
// - third unit channels B, C use second-port pins only when option set
package gpm_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_P4_DATA  = 8'h00;
    localparam logic [7:0] OFS_P4_LAT   = 8'h04;
    localparam logic [7:0] OFS_P4_DIR   = 8'h08;
    localparam logic [7:0] OFS_P5_DATA  = 8'h0C;
    localparam logic [7:0] OFS_P5_LAT   = 8'h10;
    localparam logic [7:0] OFS_P5_DIR   = 8'h14;
    localparam logic [7:0] OFS_P7_DATA  = 8'h18;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h1C;
    localparam logic [7:0] OFS_PIN_CFG  = 8'h20;
    localparam logic [7:0] OFS_PWM_TRI  = 8'h24;
    localparam logic [7:0] OFS_STATUS   = 8'h28;
    // field positions
    localparam int PU_BIT    = 7;
    localparam int EXT_BUS_DISABLE_BIT = 7;
    localparam int PARALLEL_PORT_PIN_SELECT_BIT = 0;
    localparam int PWMMX_BIT = 1;
    // values after reset
    localparam logic [7:0] RST_P4_DIR  = 8'hFF;
    localparam logic [7:0] RST_P4_LAT  = 8'h00;
    localparam logic [4:0] RST_P5_DIR  = 5'h1F;
    localparam logic [4:0] RST_P5_LAT  = 5'h00;
    localparam logic       RST_PU_EN   = 1'b0;
    localparam logic       RST_EXT_BUS_DISABLE   = 1'b1;
    localparam logic       RST_PARALLEL_PORT_PIN_SELECT   = 1'b1;
    localparam logic       RST_PWMMX   = 1'b1;
    localparam logic [4:0] RST_PWM_TRI = 5'h00;
    // source that owns a pin, highest priority last
    typedef enum logic [1:0] {
        SRC_PORT,
        SRC_PMP,
        SRC_PWM,
        SRC_EXT
    } gpm_src_t;
endpackage

// ### rtl/gpm_pin_cell.sv
// one pin's output selection with registered drive and enable
// assumes the select inputs are already qualified by the top
`timescale 1ns/100ps
`default_nettype none
module gpm_pin_cell (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // external bus
    input  wire logic i_ext_sel,
    input  wire logic i_ext_out,
    input  wire logic i_ext_oe,
    // pwm channel
    input  wire logic i_pwm_sel,
    input  wire logic i_pwm_out,
    input  wire logic i_pwm_tri,
    // parallel port
    input  wire logic i_pmp_sel,
    input  wire logic i_pmp_out,
    input  wire logic i_pmp_oe,
    // plain port
    input  wire logic i_dir,
    input  wire logic i_lat,
    // pad drive
    output logic      o_out,
    output logic      o_oe
);
    gpm_pkg::gpm_src_t src;
    logic              out_next;
    logic              oe_next;

    assign src = i_ext_sel ? gpm_pkg::SRC_EXT :
                 i_pwm_sel ? gpm_pkg::SRC_PWM :
                 i_pmp_sel ? gpm_pkg::SRC_PMP :
                             gpm_pkg::SRC_PORT;

    always_comb begin
        unique case (src)
            gpm_pkg::SRC_EXT: begin
                out_next = i_ext_out;
                oe_next  = i_ext_oe;
            end
            gpm_pkg::SRC_PWM: begin
                out_next = i_pwm_out;
                oe_next  = !i_pwm_tri;
            end
            gpm_pkg::SRC_PMP: begin
                out_next = i_pmp_out;
                oe_next  = i_pmp_oe;
            end
            gpm_pkg::SRC_PORT: begin
                out_next = i_lat;
                oe_next  = !i_dir;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_out <= 1'b0;
            o_oe  <= 1'b0;
        end else begin
            o_out <= out_next;
            o_oe  <= oe_next;
        end
    end
endmodule
`default_nettype wire

// ### rtl/gpm_apb_slave.sv
// apb handshake: one wait state, registered read data and error
// assumes the top supplies read data and a mapped flag for paddr
`timescale 1ns/100ps
`default_nettype none
module gpm_apb_slave (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // apb request
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    // register file side
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_mapped,
    output logic             o_wr_ok,
    // apb answer
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr
);
    logic first_access;

    assign first_access = i_psel && i_penable && !o_pready;
    // write takes effect at the edge where pready is seen high
    assign o_wr_ok = i_psel && i_penable && o_pready && i_mapped;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= first_access;
            o_prdata  <= first_access ? i_rdata : 32'h0000_0000;
            o_pslverr <= first_access && !i_mapped;
        end
    end
endmodule
`default_nettype wire

// ### rtl/gpm_port_mux.sv
// top of the pin logic for the first port and pins 0-4 of the second port
// assumes pads resolve drive, enable and pull-up; peripherals are outside
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module gpm_port_mux #(
    parameter int  ADDR_W    = 8,
    parameter bit  LARGE_PKG = 1'b1
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // apb
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic                   o_pready,
    output logic [31:0]            o_prdata,
    output logic                   o_pslverr,
    // first port pads
    input  wire logic [7:0]        i_port4_in,
    output logic      [7:0]        o_port4_out,
    output logic      [7:0]        o_port4_oe,
    output logic      [7:0]        o_port4_pullup,
    output logic      [7:0]        o_port4_ttl,
    // second port pads, pins 0-4
    input  wire logic [4:0]        i_port5_in,
    output logic      [4:0]        o_port5_out,
    output logic      [4:0]        o_port5_oe,
    output logic      [4:0]        o_port5_ttl,
    // external memory interface
    input  wire logic [12:0]       i_ext_bus_out,
    input  wire logic [12:0]       i_ext_bus_oe,
    output logic      [12:0]       o_ext_bus_in,
    // parallel master port
    input  wire logic              i_pmp_enable,
    input  wire logic [7:0]        i_pmp_data_out,
    input  wire logic [7:0]        i_pmp_data_oe,
    output logic      [7:0]        o_pmp_data_in,
    input  wire logic [4:0]        i_pmp_ctrl_out,
    input  wire logic [4:0]        i_pmp_ctrl_oe,
    output logic      [1:0]        o_pmp_strobe_in,
    // pwm channels: 2D, 2C, 2B, 3C, 3B on pins 0-4
    input  wire logic [4:0]        i_pwm_out,
    input  wire logic [4:0]        i_pwm_en,
    input  wire logic [1:0]        i_pwm_shutdown
);
    if (ADDR_W < 8) begin : g_chk
        $error("gpm_port_mux: ADDR_W must be at least 8");
    end

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // software registers
    logic [7:0] dir4_reg;
    logic [7:0] lat4_reg;
    logic [4:0] dir5_reg;
    logic [4:0] lat5_reg;
    logic       pu_en_reg;
    logic       ext_bus_disable_reg;
    logic       parallel_port_pin_select_reg;
    logic       pwmmx_reg;
    logic [4:0] pwm_tri_reg;

    // bus decode
    logic        wr_ok;
    logic        wr;
    logic        mapped;
    logic [31:0] rdata;
    logic        wr_p4_lat;
    logic        wr_p4_dir;
    logic        wr_p5_lat;
    logic        wr_p5_dir;
    logic        wr_p7;
    logic        wr_mem;
    logic        wr_cfg;
    logic        wr_tri;

    assign wr        = wr_ok && i_pwrite;
    assign wr_p4_lat = wr && (hit(i_paddr, gpm_pkg::OFS_P4_DATA) ||
                              hit(i_paddr, gpm_pkg::OFS_P4_LAT));
    assign wr_p4_dir = wr && hit(i_paddr, gpm_pkg::OFS_P4_DIR);
    assign wr_p5_lat = wr && (hit(i_paddr, gpm_pkg::OFS_P5_DATA) ||
                              hit(i_paddr, gpm_pkg::OFS_P5_LAT));
    assign wr_p5_dir = wr && hit(i_paddr, gpm_pkg::OFS_P5_DIR);
    assign wr_p7     = wr && hit(i_paddr, gpm_pkg::OFS_P7_DATA);
    assign wr_mem    = wr && hit(i_paddr, gpm_pkg::OFS_MEM_CTRL);
    assign wr_cfg    = wr && hit(i_paddr, gpm_pkg::OFS_PIN_CFG);
    assign wr_tri    = wr && hit(i_paddr, gpm_pkg::OFS_PWM_TRI);

    assign mapped = hit(i_paddr, gpm_pkg::OFS_P4_DATA)  ||
                    hit(i_paddr, gpm_pkg::OFS_P4_LAT)   ||
                    hit(i_paddr, gpm_pkg::OFS_P4_DIR)   ||
                    hit(i_paddr, gpm_pkg::OFS_P5_DATA)  ||
                    hit(i_paddr, gpm_pkg::OFS_P5_LAT)   ||
                    hit(i_paddr, gpm_pkg::OFS_P5_DIR)   ||
                    hit(i_paddr, gpm_pkg::OFS_P7_DATA)  ||
                    hit(i_paddr, gpm_pkg::OFS_MEM_CTRL) ||
                    hit(i_paddr, gpm_pkg::OFS_PIN_CFG)  ||
                    hit(i_paddr, gpm_pkg::OFS_PWM_TRI)  ||
                    hit(i_paddr, gpm_pkg::OFS_STATUS);

    // function ownership
    logic       ext_act;
    logic       pmp_act;
    logic       pmp_on4;
    logic [4:0] pwm_pin_ok;
    logic [4:0] pwm_sel;
    logic [4:0] pwm_unit_sd;
    logic [4:0] pwm_tri;

    assign ext_act     = LARGE_PKG && !ext_bus_disable_reg;
    assign pmp_act     = i_pmp_enable && parallel_port_pin_select_reg;
    assign pmp_on4     = pmp_act && !ext_act;
    assign pwm_pin_ok  = {pwmmx_reg, pwmmx_reg, 3'h7};
    assign pwm_sel     = i_pwm_en & ~dir5_reg & pwm_pin_ok;
    assign pwm_unit_sd = {{2{i_pwm_shutdown[1]}}, {3{i_pwm_shutdown[0]}}};
    assign pwm_tri     = pwm_tri_reg & pwm_unit_sd;

    assign rdata =
        (hit(i_paddr, gpm_pkg::OFS_P4_DATA))  ? {24'h0, i_port4_in} :
        (hit(i_paddr, gpm_pkg::OFS_P4_LAT))   ? {24'h0, lat4_reg} :
        (hit(i_paddr, gpm_pkg::OFS_P4_DIR))   ? {24'h0, dir4_reg} :
        (hit(i_paddr, gpm_pkg::OFS_P5_DATA))  ? {27'h0, i_port5_in} :
        (hit(i_paddr, gpm_pkg::OFS_P5_LAT))   ? {27'h0, lat5_reg} :
        (hit(i_paddr, gpm_pkg::OFS_P5_DIR))   ? {27'h0, dir5_reg} :
        (hit(i_paddr, gpm_pkg::OFS_P7_DATA))  ? {24'h0, pu_en_reg, 7'h0} :
        (hit(i_paddr, gpm_pkg::OFS_MEM_CTRL)) ? {24'h0, ext_bus_disable_reg, 7'h0} :
        (hit(i_paddr, gpm_pkg::OFS_PIN_CFG))  ? {30'h0, pwmmx_reg,
                                                 parallel_port_pin_select_reg} :
        (hit(i_paddr, gpm_pkg::OFS_PWM_TRI))  ? {27'h0, pwm_tri_reg} :
        (hit(i_paddr, gpm_pkg::OFS_STATUS))   ? {22'h0, pmp_on4, ext_act,
                                                 o_port4_pullup} :
                                                32'h0000_0000;

    gpm_apb_slave u_apb (
        .i_mclk    (i_mclk),
        .i_rst_n   (i_rst_n),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_rdata   (rdata),
        .i_mapped  (mapped),
        .o_wr_ok   (wr_ok),
        .o_pready  (o_pready),
        .o_prdata  (o_prdata),
        .o_pslverr (o_pslverr)
    );

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir4_reg    <= gpm_pkg::RST_P4_DIR;
            lat4_reg    <= gpm_pkg::RST_P4_LAT;
            dir5_reg    <= gpm_pkg::RST_P5_DIR;
            lat5_reg    <= gpm_pkg::RST_P5_LAT;
            pu_en_reg   <= gpm_pkg::RST_PU_EN;
            ext_bus_disable_reg   <= gpm_pkg::RST_EXT_BUS_DISABLE;
            parallel_port_pin_select_reg   <= gpm_pkg::RST_PARALLEL_PORT_PIN_SELECT;
            pwmmx_reg   <= gpm_pkg::RST_PWMMX;
            pwm_tri_reg <= gpm_pkg::RST_PWM_TRI;
        end else begin
            if (wr_p4_lat) lat4_reg <= i_pwdata[7:0];
            if (wr_p4_dir) dir4_reg <= i_pwdata[7:0];
            if (wr_p5_lat) lat5_reg <= i_pwdata[4:0];
            if (wr_p5_dir) dir5_reg <= i_pwdata[4:0];
            if (wr_p7) pu_en_reg <= i_pwdata[gpm_pkg::PU_BIT];
            if (wr_mem) ext_bus_disable_reg <= i_pwdata[gpm_pkg::EXT_BUS_DISABLE_BIT];
            if (wr_cfg) begin
                parallel_port_pin_select_reg <= i_pwdata[gpm_pkg::PARALLEL_PORT_PIN_SELECT_BIT];
                pwmmx_reg <= i_pwdata[gpm_pkg::PWMMX_BIT];
            end
            if (wr_tri) pwm_tri_reg <= i_pwdata[4:0];
        end
    end

    // pad controls and inputs toward peripherals
    logic [7:0] pullup_next;
    logic [4:0] ttl5_next;

    assign pullup_next = {8{pu_en_reg}} & dir4_reg;
    assign ttl5_next   = ext_act ? 5'h1F :
                         {3'h0, {2{pmp_act}}};

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_port4_pullup  <= 8'h00;
            o_port4_ttl     <= 8'h00;
            o_port5_ttl     <= 5'h00;
            o_ext_bus_in    <= 13'h0000;
            o_pmp_data_in   <= 8'h00;
            o_pmp_strobe_in <= 2'h0;
        end else begin
            o_port4_pullup  <= pullup_next;
            o_port4_ttl     <= {8{pmp_on4}};
            o_port5_ttl     <= ttl5_next;
            o_ext_bus_in    <= {i_port5_in, i_port4_in};
            o_pmp_data_in   <= i_port4_in;
            o_pmp_strobe_in <= i_port5_in[1:0];
        end
    end

    // first port: external bus, then parallel data, then plain port
    for (genvar i = 0; i < 8; i++) begin : g_p4
        gpm_pin_cell u_cell (
            .i_mclk    (i_mclk),
            .i_rst_n   (i_rst_n),
            .i_ext_sel (ext_act),
            .i_ext_out (i_ext_bus_out[i]),
            .i_ext_oe  (i_ext_bus_oe[i]),
            .i_pwm_sel (1'b0),
            .i_pwm_out (1'b0),
            .i_pwm_tri (1'b0),
            .i_pmp_sel (pmp_act),
            .i_pmp_out (i_pmp_data_out[i]),
            .i_pmp_oe  (i_pmp_data_oe[i]),
            .i_dir     (dir4_reg[i]),
            .i_lat     (lat4_reg[i]),
            .o_out     (o_port4_out[i]),
            .o_oe      (o_port4_oe[i])
        );
    end

    // second port: bus bits 8-12, pwm, parallel strobes/address, port
    for (genvar i = 0; i < 5; i++) begin : g_p5
        gpm_pin_cell u_cell (
            .i_mclk    (i_mclk),
            .i_rst_n   (i_rst_n),
            .i_ext_sel (ext_act),
            .i_ext_out (i_ext_bus_out[8+i]),
            .i_ext_oe  (i_ext_bus_oe[8+i]),
            .i_pwm_sel (pwm_sel[i]),
            .i_pwm_out (i_pwm_out[i]),
            .i_pwm_tri (pwm_tri[i]),
            .i_pmp_sel (pmp_act),
            .i_pmp_out (i_pmp_ctrl_out[i]),
            .i_pmp_oe  (i_pmp_ctrl_oe[i]),
            .i_dir     (dir5_reg[i]),
            .i_lat     (lat5_reg[i]),
            .o_out     (o_port5_out[i]),
            .o_oe      (o_port5_oe[i])
        );
    end

    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_apb_write_done;
        i_psel && i_penable && o_pready && i_pwrite && mapped;
    endsequence

    property p_plain_drive;
        (!ext_act && !pmp_act) |=> (o_port4_oe == ~$past(dir4_reg)) &&
            (o_port4_out == $past(lat4_reg));
    endproperty
    a_plain_drive: assert property (p_plain_drive)
        else $error("plain port drive does not follow latch and direction");

    property p_ext_low_byte;
        ext_act |=> (o_port4_oe == $past(i_ext_bus_oe[7:0])) &&
            (o_port4_out == $past(i_ext_bus_out[7:0]));
    endproperty
    a_ext_low_byte: assert property (p_ext_low_byte)
        else $error("external bus does not own the first port");

    property p_pmp_below_ext;
        (pmp_act && !ext_act) |=>
            (o_port4_out == $past(i_pmp_data_out)) &&
            (o_port4_ttl == 8'hFF);
    endproperty
    a_pmp_below_ext: assert property (p_pmp_below_ext)
        else $error("parallel data not on the first port");

    property p_pullup_off_output;
        1'b1 |=> (o_port4_pullup & ~$past(dir4_reg)) == 8'h00;
    endproperty
    a_pullup_off_output: assert property (p_pullup_off_output)
        else $error("pull-up on while pin is an output");

    property p_pullup_shared_off;
        !pu_en_reg |=> o_port4_pullup == 8'h00;
    endproperty
    a_pullup_shared_off: assert property (p_pullup_shared_off)
        else $error("pull-ups on with shared bit cleared");

    property p_latch_write;
        s_apb_write_done ##0 hit(i_paddr, gpm_pkg::OFS_P4_DATA) |=>
            lat4_reg == $past(i_pwdata[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port data write did not load the latch");

    property p_pwm_shutdown;
        (!ext_act && pwm_sel[0] && pwm_tri[0]) |=> !o_port5_oe[0];
    endproperty
    a_pwm_shutdown: assert property (p_pwm_shutdown)
        else $error("pwm pin driven during shutdown");

    property p_pwm_over_pmp;
        (!ext_act && pwm_sel[2] && !pwm_tri[2]) |=>
            o_port5_oe[2] && (o_port5_out[2] == $past(i_pwm_out[2]));
    endproperty
    a_pwm_over_pmp: assert property (p_pwm_over_pmp)
        else $error("pwm output does not own its pin");

    property p_ext_high_ttl;
        ext_act |=> (o_port5_ttl == 5'h1F) &&
            (o_port5_oe == $past(i_ext_bus_oe[12:8]));
    endproperty
    a_ext_high_ttl: assert property (p_ext_high_ttl)
        else $error("bus bits 8-12 not on the second port");

    property p_apb_answer;
        (i_psel && !i_penable) ##1 (i_psel && i_penable) |-> ##1 o_pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not in the second access cycle");
endmodule
`default_nettype wire

// ### sim/gpm_pad_model.sv
// board side of a group of pads: resolves each pin level
// assumes drive from the block wins over the board drive
`timescale 1ns/100ps
`default_nettype none
module gpm_pad_model #(
    parameter int W = 8
) (
    // clock
    input  wire logic         i_mclk,
    // block side of the pads
    input  wire logic [W-1:0] i_pad_out,
    input  wire logic [W-1:0] i_pad_oe,
    input  wire logic [W-1:0] i_pad_pu,
    // board drive
    input  wire logic [W-1:0] i_brd_val,
    input  wire logic [W-1:0] i_brd_oe,
    // resolved pin level
    output logic      [W-1:0] o_pin
);
    logic [W-1:0] last_reg = '0;

    // an undriven pin without pull-up toggles so no stale level passes
    always_ff @(posedge i_mclk) last_reg <= o_pin;

    always_comb begin
        for (int b = 0; b < W; b++) begin
            if (i_pad_oe[b]) o_pin[b] = i_pad_out[b];
            else if (i_brd_oe[b]) o_pin[b] = i_brd_val[b];
            else if (i_pad_pu[b]) o_pin[b] = 1'b1;
            else o_pin[b] = ~last_reg[b];
        end
    end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the port pin mux
// assumes the pad model stands on both pad groups
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        i_mclk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 0, pdout = 0, pdoe = 0, out4, oe4, pu4, ttl4;
    logic [7:0]  pin4, pdin, rnd = 8'h2C, dir;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, pe, pmp_en = 0;
    logic [4:0]  out5, oe5, ttl5, pin5, cout = 0, coe = 0;
    logic [4:0]  pwm = 0, pwm_en = 0;
    logic [12:0] ext_out = 0, ext_oe = 0, ext_in;
    logic [1:0]  sd = 0, strb;
    logic [7:0]  bv4 = 0, bo4 = 0;
    logic [4:0]  bv5 = 0, bo5 = 0;
    int          err_total = 0, n_compared = 0;

    always #2 i_mclk = ~i_mclk;

    gpm_port_mux gpm_port_mux_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_port4_in(pin4), .o_port4_out(out4),
        .o_port4_oe(oe4), .o_port4_pullup(pu4), .o_port4_ttl(ttl4),
        .i_port5_in(pin5), .o_port5_out(out5), .o_port5_oe(oe5),
        .o_port5_ttl(ttl5), .i_ext_bus_out(ext_out), .i_ext_bus_oe(ext_oe),
        .o_ext_bus_in(ext_in), .i_pmp_enable(pmp_en), .i_pmp_data_out(pdout),
        .i_pmp_data_oe(pdoe), .o_pmp_data_in(pdin), .i_pmp_ctrl_out(cout),
        .i_pmp_ctrl_oe(coe), .o_pmp_strobe_in(strb), .i_pwm_out(pwm),
        .i_pwm_en(pwm_en), .i_pwm_shutdown(sd));
    gpm_pad_model #(.W(8)) pad4_model (.i_mclk(i_mclk), .i_pad_out(out4),
        .i_pad_oe(oe4), .i_pad_pu(pu4), .i_brd_val(bv4),
        .i_brd_oe(bo4), .o_pin(pin4));
    gpm_pad_model #(.W(5)) pad5_model (.i_mclk(i_mclk), .i_pad_out(out5),
        .i_pad_oe(oe5), .i_pad_pu(5'h00), .i_brd_val(bv5),
        .i_brd_oe(bo5), .o_pin(pin5));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected pin level: block drive, then board drive, then pull-up
    function automatic logic [7:0] pin_exp(input logic [7:0] lat, dir, bv,
                                           bo);
        return (lat & ~dir) | (dir & bo & bv) | (dir & ~bo);
    endfunction

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, e, input string m);
        n_compared++;
        if (g !== e) begin
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
            err_total++;
        end
    endtask

    // one apb transfer; holds the request until pready is seen high or 20 cycles pass
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        pen <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        pe = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            $display("BAD %0t no pready", $time);
            err_total++;
            close_out;
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e, m);
    endtask

    task automatic settle;
        repeat (3) @(posedge i_mclk);
    endtask

    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        chk(oe4, 0, "oe after reset");
        chk(pu4, 0, "pullup after reset");
        rdchk(8'h08, 32'h0000_00FF, "dir4 reset");
        rdchk(8'h18, 32'h0000_0000, "pullup enable reset");
        rdchk(8'h1C, 32'h0000_0080, "bus disable reset");
        apb(1'b1, 8'h18, 32'h0000_0080);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            bv4 <= rnd;
            rnd = lfsr(rnd);
            bo4 <= rnd;
            rnd = lfsr(rnd);
            dir = rnd;
            apb(1'b1, 8'h08, {24'h00_0000, dir});
            rnd = lfsr(rnd);
            apb(1'b1, i[0] ? 8'h00 : 8'h04, {24'h00_0000, rnd});
            settle;
            chk(oe4, 8'(~dir), "plain drive enable");
            chk(out4, rnd, "plain drive value");
            chk(pu4, dir, "pullup follows direction");
            chk(ttl4, 0, "schmitt inputs");
            rdchk(8'h00, pin_exp(rnd, dir, bv4, bo4), "pin levels");
        end
        apb(1'b1, 8'h18, 32'h0000_0000);
        settle;
        chk(pu4, 0, "shared pullup off");
        apb(1'b1, 8'h18, 32'h0000_0080);
        settle;
        chk(pu4, dir, "pullup back on");
        i_rst_n <= 1'b0;
        @(posedge i_mclk);
        chk(pu4, 0, "pullup after mid-run reset");
        chk(oe4, 0, "oe after mid-run reset");
        i_rst_n <= 1'b1;
        rdchk(8'h08, 32'h0000_00FF, "dir4 after mid-run reset");
        bv5 <= rnd[4:0];
        bo5 <= 5'h1F;
        settle;
        rdchk(8'h0C, {27'h0, rnd[4:0]}, "second port input");
        pmp_en <= 1'b1;
        pdout <= rnd;
        pdoe <= 8'hFF;
        cout <= dir[4:0];
        coe <= 5'h1F;
        settle;
        chk(out4, rnd, "parallel data out");
        chk(oe4, 8'hFF, "parallel data enable");
        chk(ttl5, 5'h03, "parallel strobe ttl");
        chk(ttl4, 8'hFF, "parallel ttl");
        chk(pdin, pin4, "parallel data in");
        chk(out5, dir[4:0], "parallel strobes");
        chk(strb, pin5[1:0], "strobe inputs");
        apb(1'b1, 8'h14, 32'h0000_0000);
        pwm_en <= 5'h1F;
        pwm <= rnd[7:3];
        settle;
        chk(out5, rnd[7:3], "pwm beats parallel");
        chk(oe5, 5'h1F, "pwm drive");
        apb(1'b1, 8'h20, 32'h0000_0001);
        settle;
        chk(out5, {dir[4:3], rnd[5:3]}, "pwm pins need select");
        apb(1'b1, 8'h20, 32'h0000_0000);
        settle;
        chk(ttl4, 0, "parallel select off ttl");
        chk(out5, {2'b00, rnd[5:3]}, "parallel select off pins");
        apb(1'b1, 8'h20, 32'h0000_0003);
        apb(1'b1, 8'h24, 32'h0000_001F);
        sd <= 2'b01;
        settle;
        chk(oe5, 5'h18, "unit two shutdown float");
        sd <= 2'b11;
        settle;
        chk(oe5, 5'h00, "both shutdown float");
        ext_out <= {rnd[4:0], dir};
        ext_oe <= 13'h1FFF;
        apb(1'b1, 8'h1C, 32'h0000_0000);
        settle;
        chk(out4, dir, "bus low byte");
        chk(oe4, 8'hFF, "bus beats parallel");
        chk(out5, rnd[4:0], "bus high bits");
        chk(ttl5, 5'h1F, "bus ttl");
        chk(ext_in, {pin5, pin4}, "bus input");
        rdchk(8'h28, 32'h0000_0100, "status bus active");
        rdchk(8'h3C, 32'h0000_0000, "unmapped read data");
        chk(pe, 1'b1, "unmapped error");
        close_out;
    end
endmodule
`default_nettype wire
